// ==== pmwg_pkg.sv ====
`default_nettype none
package pmwg_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int LOCK_TIME_US = 2200;
  localparam int LOCK_CYCLES = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_UV_PER_NS = 10;
  localparam int STEP_UV_BUCK12 = 20000;
  localparam int STEP_UV_BUCK34 = 6250;
  localparam int STEP_CYC_BUCK12_RAW = STEP_UV_BUCK12 / RAMP_UV_PER_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC_BUCK34_RAW = STEP_UV_BUCK34 / RAMP_UV_PER_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC_BUCK12 = (STEP_CYC_BUCK12_RAW < 1) ? 1 : STEP_CYC_BUCK12_RAW;
  localparam int STEP_CYC_BUCK34 = (STEP_CYC_BUCK34_RAW < 1) ? 1 : STEP_CYC_BUCK34_RAW;
  localparam int NUM_OUT = 5;
  localparam logic [6:0] DEV_ADDR = 7'h2d;
  localparam logic [7:0] REG_ADC_EN = 8'h01;
  localparam logic [7:0] REG_LINEAR = 8'h10;
  localparam logic [7:0] REG_BUCK4 = 8'h14;
  localparam logic [7:0] REG_TEMP = 8'h1b;
  localparam logic [7:0] REG_EXT_A = 8'h1c;
  localparam logic [7:0] REG_EXT_B = 8'h1d;
  localparam logic ADC_EN_RST = 1'h1;
  localparam logic [7:0] LINEAR_RST = 8'ha5;
  localparam logic [7:0] BUCK_RST = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_REG = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  localparam logic [1:0] SEL_EXT_A = 2'h0;
  localparam logic [1:0] SEL_EXT_B = 2'h1;
  localparam logic [1:0] SEL_TEMP = 2'h2;
  typedef struct packed {
    logic [7:0] code;
    logic ramping;
    logic locked;
  } pmwg_chan_t;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX = 3'b001,
    I2C_ACK = 3'b010,
    I2C_TX = 3'b011,
    I2C_MACK = 3'b100
  } pmwg_i2c_state_t;
  typedef enum logic [1:0] {
    ADC_CAL_GO = 2'b00,
    ADC_CAL_WAIT = 2'b01,
    ADC_IDLE = 2'b10,
    ADC_CONV = 2'b11
  } pmwg_adc_state_t;
endpackage
`default_nettype wire

// ==== pmwg_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmwg_chan #(
  parameter int LOCK_CYCLES = pmwg_pkg::LOCK_CYCLES,
  parameter int STEP_CYCLES = pmwg_pkg::STEP_CYC_BUCK12,
  parameter bit RAMP_EN = 1'b1,
  parameter logic [7:0] RESET_CODE = pmwg_pkg::BUCK_RST
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic writeAccept,
  input wire logic [7:0] target,
  output pmwg_pkg::pmwg_chan_t status
);
  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam int SW = $clog2(STEP_CYCLES + 1);
  logic [LW-1:0] lockCnt_q, lockCnt_d;
  logic [SW-1:0] stepCnt_q, stepCnt_d;
  logic [7:0] code_q, code_d;
  logic stepDone;

  assign stepDone = (stepCnt_q == SW'(STEP_CYCLES - 1));
  assign status.code = code_q;
  assign status.ramping = RAMP_EN && (code_q != target);
  assign status.locked = (lockCnt_q != '0);

  always_comb begin
    lockCnt_d = lockCnt_q;
    if (writeAccept) begin
      lockCnt_d = LW'(LOCK_CYCLES); // [RULE_12]
    end else if (lockCnt_q != '0) begin
      lockCnt_d = lockCnt_q - 1'b1; // [RULE_12]
    end
    stepCnt_d = '0;
    code_d = code_q;
    if (!RAMP_EN) begin
      code_d = target;
    end else if (code_q != target) begin
      if (stepDone) begin
        code_d = (code_q < target) ? code_q + 8'h01 : code_q - 8'h01; // [RULE_05]
      end else begin
        stepCnt_d = stepCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockCnt_q <= '0;
      stepCnt_q <= '0;
      code_q <= RESET_CODE;
    end else begin
      lockCnt_q <= lockCnt_d;
      stepCnt_q <= stepCnt_d;
      code_q <= code_d;
    end
  end

  oneChange_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_03]
    writeAccept |=> status.locked [*8])
    else $error("channel lockout did not hold after an accepted write");
  lockStart_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_12]
    $rose(status.locked) |-> $past(writeAccept))
    else $error("lockout started without an accepted write");
  rampStep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_05]
    (status.ramping && stepDone && $stable(target)) |=>
      (code_q == $past(code_q) + 8'h01) || (code_q == $past(code_q) - 8'h01))
    else $error("ramp step did not move the code by one");
  rampSeen_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(status.ramping));
endmodule
`default_nettype wire

// ==== pmwg_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01: The serial clock is never held low; anything that cannot be served is refused by a NAK.
// RULE_02: A setpoint write arriving less than the lockout time after the last write to it is NAKed.
// RULE_03: Each output accepts only one setpoint change within any lockout window.
// RULE_04: The host waits the lockout time after its last setpoint write before writing again.
// RULE_05: Each buck output ramps toward a new setpoint at the nominal slew rate.
// RULE_06: One 8-bit converter is shared by the two external inputs and the temperature sensor.
// RULE_07: The die temperature register returns the latest temperature conversion.
// RULE_08: The two external input registers return their latest conversions.
// RULE_09: The converter enable resets to enabled and calibration runs at every power-up.
// RULE_10: A setpoint write to an output still ramping is NAKed.
// RULE_11: An output's in-regulation flag is forced high while ramping and re-evaluated after.
// RULE_12: Each setpoint has its own lockout timer, started only by an acknowledged write.
module pmwg_top #(
  parameter logic [6:0] I2C_ADDR = pmwg_pkg::DEV_ADDR,
  parameter int LOCK_CYCLES = pmwg_pkg::LOCK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [4:0] regulationRaw,
  output logic [4:0] outputInRegulation,
  output logic [4:0][7:0] outputCode,
  output logic [1:0] adcSel,
  output logic adcStart,
  output logic adcCalStart,
  input wire logic [7:0] adcSample,
  input wire logic adcDone,
  input wire logic adcCalDone
);
  logic [2:0] sclPipe_q, sclPipe_d, sdaPipe_q, sdaPipe_d;
  logic [4:0] regS1_q, regS2_q;
  logic sclRise, sclFall, sdaBit, startCond, stopCond;
  pmwg_pkg::pmwg_i2c_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d, tx_q, tx_d, readData;
  logic [1:0] kind_q, kind_d;
  logic rw_q, rw_d, ack_q, ack_d, mAck_q, mAck_d, adcEn_q, adcEn_d;
  logic [4:0][7:0] spt_q, spt_d;
  logic [4:0] acceptVec, chanRamp, chanLock;
  logic decide, loadTx, sptHit, sptBlocked;
  logic [2:0] sptIdx;
  pmwg_pkg::pmwg_chan_t chanSt[5];
  pmwg_pkg::pmwg_adc_state_t adcState_q, adcState_d;
  logic [1:0] sel_q, sel_d;
  logic adcStart_q, adcStart_d, adcCalStart_q, adcCalStart_d, calSeen_q, calSeen_d;
  logic [7:0] temp_q, temp_d, extA_q, extA_d, extB_q, extB_d;

  // Pins are asynchronous; stage 2 is the first that logic reads
  assign sclPipe_d = {sclPipe_q[1:0], sclIn};
  assign sdaPipe_d = {sdaPipe_q[1:0], sdaIn};
  assign sclRise = sclPipe_q[1] & ~sclPipe_q[2];
  assign sclFall = ~sclPipe_q[1] & sclPipe_q[2];
  assign sdaBit = sdaPipe_q[1];
  assign startCond = sclPipe_q[1] & sclPipe_q[2] & sdaPipe_q[2] & ~sdaPipe_q[1];
  assign stopCond = sclPipe_q[1] & sclPipe_q[2] & ~sdaPipe_q[2] & sdaPipe_q[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPipe_q <= 3'h7;
      sdaPipe_q <= 3'h7;
      regS1_q <= 5'h00;
      regS2_q <= 5'h00;
    end else begin
      sclPipe_q <= sclPipe_d;
      sdaPipe_q <= sdaPipe_d;
      regS1_q <= regulationRaw;
      regS2_q <= regS1_q;
    end
  end

  genvar g;
  for (g = 0; g < pmwg_pkg::NUM_OUT; g++) begin : gChan
    pmwg_chan #(
      .LOCK_CYCLES(LOCK_CYCLES),
      .STEP_CYCLES((g <= 2) ? pmwg_pkg::STEP_CYC_BUCK12 : pmwg_pkg::STEP_CYC_BUCK34),
      .RAMP_EN(g != 0),
      .RESET_CODE((g == 0) ? pmwg_pkg::LINEAR_RST : pmwg_pkg::BUCK_RST)
    ) uChan (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .writeAccept(acceptVec[g]),
      .target(spt_q[g]),
      .status(chanSt[g])
    );
    assign chanRamp[g] = chanSt[g].ramping;
    assign chanLock[g] = chanSt[g].locked;
    assign outputCode[g] = chanSt[g].code;
    assign outputInRegulation[g] = chanSt[g].ramping | regS2_q[g]; // [RULE_11]
  end

  assign sptHit = (ptr_q >= pmwg_pkg::REG_LINEAR) && (ptr_q <= pmwg_pkg::REG_BUCK4);
  assign sptIdx = 3'(ptr_q - pmwg_pkg::REG_LINEAR);
  assign sptBlocked = sptHit && (chanLock[sptIdx] || chanRamp[sptIdx]); // [RULE_02] [RULE_10]

  always_comb begin
    readData = 8'h00;
    if (sptHit) begin
      readData = spt_q[sptIdx];
    end else begin
      case (ptr_q)
        pmwg_pkg::REG_ADC_EN: readData = {7'h00, adcEn_q};
        pmwg_pkg::REG_TEMP: readData = temp_q; // [RULE_07]
        pmwg_pkg::REG_EXT_A: readData = extA_q; // [RULE_08]
        pmwg_pkg::REG_EXT_B: readData = extB_q; // [RULE_08]
        default: readData = 8'h00;
      endcase
    end
  end

  // No stretching: every refusal is decided at the ack slot instead
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    kind_d = kind_q;
    rw_d = rw_q;
    ack_d = ack_q;
    mAck_d = mAck_q;
    adcEn_d = adcEn_q;
    spt_d = spt_q;
    acceptVec = 5'h00;
    decide = 1'b0;
    loadTx = 1'b0;
    if (startCond) begin
      state_d = pmwg_pkg::I2C_RX;
      cnt_d = 4'h0;
      kind_d = pmwg_pkg::KIND_ADDR;
    end else if (stopCond) begin
      state_d = pmwg_pkg::I2C_IDLE;
    end else begin
      case (state_q)
        pmwg_pkg::I2C_IDLE: begin
        end
        pmwg_pkg::I2C_RX: begin
          if (sclRise && cnt_q != pmwg_pkg::BYTE_BITS) begin
            shift_d = {shift_q[6:0], sdaBit};
            cnt_d = cnt_q + 4'h1;
          end else if (sclFall && cnt_q == pmwg_pkg::BYTE_BITS) begin
            decide = 1'b1;
            state_d = pmwg_pkg::I2C_ACK;
            ack_d = 1'b1;
            if (kind_q == pmwg_pkg::KIND_ADDR) begin
              if (shift_q[7:1] != I2C_ADDR) begin
                state_d = pmwg_pkg::I2C_IDLE;
              end
              rw_d = shift_q[0];
            end else if (kind_q == pmwg_pkg::KIND_REG) begin
              ptr_d = shift_q;
            end else if (sptBlocked) begin
              ack_d = 1'b0; // [RULE_01] [RULE_02] [RULE_03] [RULE_10]
            end else begin
              if (sptHit) begin
                spt_d[sptIdx] = shift_q;
                acceptVec[sptIdx] = 1'b1; // [RULE_12]
              end else if (ptr_q == pmwg_pkg::REG_ADC_EN) begin
                adcEn_d = shift_q[0];
              end
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        pmwg_pkg::I2C_ACK: begin
          if (sclFall) begin
            if (!ack_q) begin
              state_d = pmwg_pkg::I2C_IDLE;
            end else if (kind_q == pmwg_pkg::KIND_ADDR && rw_q) begin
              state_d = pmwg_pkg::I2C_TX;
              loadTx = 1'b1;
            end else begin
              state_d = pmwg_pkg::I2C_RX;
              cnt_d = 4'h0;
              kind_d = (kind_q == pmwg_pkg::KIND_ADDR) ? pmwg_pkg::KIND_REG : pmwg_pkg::KIND_DATA;
            end
          end
        end
        pmwg_pkg::I2C_TX: begin
          if (sclFall) begin
            if (cnt_q == pmwg_pkg::BYTE_BITS - 4'h1) begin
              state_d = pmwg_pkg::I2C_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        pmwg_pkg::I2C_MACK: begin
          if (sclRise) begin
            mAck_d = ~sdaBit;
          end else if (sclFall) begin
            if (mAck_q) begin
              state_d = pmwg_pkg::I2C_TX;
              loadTx = 1'b1;
            end else begin
              state_d = pmwg_pkg::I2C_IDLE;
            end
          end
        end
        default: state_d = pmwg_pkg::I2C_IDLE;
      endcase
    end
    if (loadTx) begin
      tx_d = readData;
      ptr_d = ptr_q + 8'h01;
      cnt_d = 4'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmwg_pkg::I2C_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      kind_q <= pmwg_pkg::KIND_ADDR;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      mAck_q <= 1'b0;
      adcEn_q <= pmwg_pkg::ADC_EN_RST; // [RULE_09]
      spt_q <= {pmwg_pkg::BUCK_RST, pmwg_pkg::BUCK_RST, pmwg_pkg::BUCK_RST,
                pmwg_pkg::BUCK_RST, pmwg_pkg::LINEAR_RST};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      kind_q <= kind_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      mAck_q <= mAck_d;
      adcEn_q <= adcEn_d;
      spt_q <= spt_d;
    end
  end

  // Open drain: only ever pulls low, and only on data, never on the clock
  assign sdaOut = 1'b0;
  assign sdaOe = (state_q == pmwg_pkg::I2C_ACK && ack_q) ||
                 (state_q == pmwg_pkg::I2C_TX && !tx_q[7]); // [RULE_01]

  // Round-robin over the three sources; calibration always first
  always_comb begin
    adcState_d = adcState_q;
    sel_d = sel_q;
    adcStart_d = 1'b0;
    adcCalStart_d = 1'b0;
    calSeen_d = calSeen_q;
    temp_d = temp_q;
    extA_d = extA_q;
    extB_d = extB_q;
    case (adcState_q)
      pmwg_pkg::ADC_CAL_GO: begin
        adcCalStart_d = 1'b1; // [RULE_09]
        adcState_d = pmwg_pkg::ADC_CAL_WAIT;
      end
      pmwg_pkg::ADC_CAL_WAIT: begin
        if (adcCalDone) begin
          calSeen_d = 1'b1;
          adcState_d = pmwg_pkg::ADC_IDLE;
        end
      end
      pmwg_pkg::ADC_IDLE: begin
        if (adcEn_q) begin
          adcStart_d = 1'b1;
          adcState_d = pmwg_pkg::ADC_CONV;
        end
      end
      pmwg_pkg::ADC_CONV: begin
        if (adcDone) begin
          adcState_d = pmwg_pkg::ADC_IDLE;
          case (sel_q) // [RULE_06]
            pmwg_pkg::SEL_EXT_A: begin
              extA_d = adcSample;
              sel_d = pmwg_pkg::SEL_EXT_B;
            end
            pmwg_pkg::SEL_EXT_B: begin
              extB_d = adcSample;
              sel_d = pmwg_pkg::SEL_TEMP;
            end
            default: begin
              temp_d = adcSample;
              sel_d = pmwg_pkg::SEL_EXT_A;
            end
          endcase
        end
      end
      default: adcState_d = pmwg_pkg::ADC_CAL_GO;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adcState_q <= pmwg_pkg::ADC_CAL_GO;
      sel_q <= pmwg_pkg::SEL_EXT_A;
      adcStart_q <= 1'b0;
      adcCalStart_q <= 1'b0;
      calSeen_q <= 1'b0;
      temp_q <= 8'h00;
      extA_q <= 8'h00;
      extB_q <= 8'h00;
    end else begin
      adcState_q <= adcState_d;
      sel_q <= sel_d;
      adcStart_q <= adcStart_d;
      adcCalStart_q <= adcCalStart_d;
      calSeen_q <= calSeen_d;
      temp_q <= temp_d;
      extA_q <= extA_d;
      extB_q <= extB_d;
    end
  end
  assign adcSel = sel_q;
  assign adcStart = adcStart_q;
  assign adcCalStart = adcCalStart_q;

  noStretch_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_01]
    sdaOe |-> (state_q == pmwg_pkg::I2C_ACK || state_q == pmwg_pkg::I2C_TX))
    else $error("data line driven outside ack or read slot");
  lockNak_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_02]
    (decide && kind_q == pmwg_pkg::KIND_DATA && sptHit && chanLock[sptIdx]) |=>
      (state_q == pmwg_pkg::I2C_ACK && !ack_q && acceptVec == 5'h00))
    else $error("write inside lockout was acknowledged");
  rampNak_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_10]
    (decide && kind_q == pmwg_pkg::KIND_DATA && sptHit && chanRamp[sptIdx]) |=> !ack_q)
    else $error("write to ramping output was acknowledged");
  pgForce_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_11]
    (chanRamp & ~outputInRegulation) == 5'h00)
    else $error("regulation flag low during ramp");
  pgReeval_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_11]
    $fell(chanRamp[4]) |-> (outputInRegulation[4] == $past(regulationRaw[4], 2)))
    else $error("regulation flag not re-evaluated after ramp");
  tempRead_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_07]
    (loadTx && ptr_q == pmwg_pkg::REG_TEMP) |=> (tx_q == $past(temp_q)))
    else $error("temperature read returned wrong data");
  extRead_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_08]
    (loadTx && ptr_q == pmwg_pkg::REG_EXT_B) |=> (tx_q == $past(extB_q)))
    else $error("second input read returned wrong data");
  adcRoute_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_06]
    (adcState_q == pmwg_pkg::ADC_CONV && adcDone && sel_q == pmwg_pkg::SEL_TEMP) |=>
      (temp_q == $past(adcSample) && sel_q == pmwg_pkg::SEL_EXT_A))
    else $error("temperature sample misrouted");
  calFirst_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_09]
    adcStart_q |-> calSeen_q)
    else $error("conversion started before calibration");
  wrAccept_c: cover property (@(posedge core_clk) disable iff (!rst_n) acceptVec != 5'h00);
  wrNak_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    decide && sptBlocked && kind_q == pmwg_pkg::KIND_DATA);
  tempRd_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    loadTx && ptr_q == pmwg_pkg::REG_TEMP);
endmodule
`default_nettype wire

// ==== pmwg_i2c_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmwg_i2c_host #(
  parameter logic [6:0] I2C_ADDR = pmwg_pkg::DEV_ADDR
) (
  input wire logic core_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sclQ = 1'b1;
  logic sdaQ = 1'b1;
  assign sclIn = sclQ;
  // Open drain with pull-up: low if either side pulls
  assign sdaIn = sdaQ & ~(sdaOe === 1'b1);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // SCL low 5 cycles, high 5; the device needs at least 3 low
  task automatic bitXfer(input logic b, output logic r);
    sclQ <= 1'b0;
    tick(2);
    sdaQ <= b;
    tick(3);
    sclQ <= 1'b1;
    tick(3);
    r = sdaIn;
    tick(2);
  endtask
  task automatic start();
    sclQ <= 1'b0;
    tick(3);
    sdaQ <= 1'b1;
    tick(3);
    sclQ <= 1'b1;
    tick(5);
    sdaQ <= 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sclQ <= 1'b0;
    tick(3);
    sdaQ <= 1'b0;
    tick(3);
    sclQ <= 1'b1;
    tick(5);
    sdaQ <= 1'b1;
    tick(5);
  endtask
  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(d[i], r);
    end
    bitXfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic byteIn(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(1'b1, r);
      d[i] = r;
    end
    bitXfer(1'b1, r);
  endtask
  task automatic writeReg(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic a1, a2, a3;
    tick(1);
    start();
    byteOut({I2C_ADDR, 1'b0}, a1);
    byteOut(ptr, a2);
    byteOut(d, a3);
    stop();
    ack = a1 & a2 & a3;
  endtask
  task automatic readReg(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    tick(1);
    start();
    byteOut({I2C_ADDR, 1'b0}, a);
    byteOut(ptr, a);
    start();
    byteOut({I2C_ADDR, 1'b1}, a);
    byteIn(d);
    stop();
  endtask
  // Host spacing between rewrites of one setpoint
  task automatic lockWait(input int n);
    tick(n);
  endtask
endmodule
`default_nettype wire

// ==== test_pmic_host_port_write_guard_adc.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_pmic_host_port_write_guard_adc;
  localparam int LOCK = 2000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclIn, sdaIn, sdaOut, sdaOe, adcStart, adcCalStart;
  logic adcDone = 1'b0;
  logic adcCalDone = 1'b0;
  logic [7:0] adcSample = 8'h00;
  logic [4:0] regulationRaw = 5'h00;
  logic [4:0] outputInRegulation;
  logic [4:0][7:0] outputCode;
  logic [1:0] adcSel;
  logic [7:0] rd;
  logic ack;
  int nMismatch = 0;
  int checked = 0;
  int nStart = 0;
  time t0;
  always #50 core_clk = ~core_clk;
  pmwg_i2c_host host_u (
    .core_clk(core_clk),
    .sdaOe(sdaOe),
    .sclIn(sclIn),
    .sdaIn(sdaIn)
  );
  pmwg_top #(.LOCK_CYCLES(LOCK)) dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .regulationRaw(regulationRaw),
    .outputInRegulation(outputInRegulation),
    .outputCode(outputCode),
    .adcSel(adcSel),
    .adcStart(adcStart),
    .adcCalStart(adcCalStart),
    .adcSample(adcSample),
    .adcDone(adcDone),
    .adcCalDone(adcCalDone)
  );
  function automatic logic [7:0] srcValue(input logic [1:0] s);
    return (s == pmwg_pkg::SEL_TEMP) ? 8'h5f : (s == pmwg_pkg::SEL_EXT_B) ? 8'h4d : 8'h3c;
  endfunction
  // Converter stand-in; result lines show a wrong value outside done
  always @(posedge core_clk) begin
    adcDone <= (adcStart === 1'b1);
    adcSample <= (adcStart === 1'b1) ? srcValue(adcSel) : ~srcValue(adcSel);
    adcCalDone <= adcCalDone | (adcCalStart === 1'b1);
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      check("resetCode", outputCode[i], (i == 0) ? 8'ha5 : 8'h00);
    end
    check("sdaOut", {7'h0, sdaOut}, 8'h00);
    rst_n <= 1'b1;
    repeat (300) @(posedge core_clk);
    check("calStarted", {7'h0, adcCalDone}, 8'h01);
    $display("Test reset done");
    host_u.readReg(pmwg_pkg::REG_ADC_EN, rd);
    check("adcEnable", rd, 8'h01);
    host_u.readReg(pmwg_pkg::REG_TEMP, rd);
    check("temp", rd, 8'h5f);
    host_u.readReg(pmwg_pkg::REG_EXT_A, rd);
    check("extA", rd, 8'h3c);
    host_u.readReg(pmwg_pkg::REG_EXT_B, rd);
    check("extB", rd, 8'h4d);
    host_u.readReg(8'h05, rd);
    check("unmapped", rd, 8'h00);
    $display("Test converter done");
    host_u.writeReg(pmwg_pkg::REG_LINEAR, 8'h33, ack);
    check("firstAck", {7'h0, ack}, 8'h01);
    host_u.writeReg(pmwg_pkg::REG_LINEAR, 8'h77, ack);
    check("earlyNak", {7'h0, ack}, 8'h00);
    host_u.readReg(pmwg_pkg::REG_LINEAR, rd);
    check("refusedKept", rd, 8'h33);
    host_u.writeReg(8'h13, 8'h04, ack);
    check("otherOutAck", {7'h0, ack}, 8'h01);
    host_u.lockWait(LOCK);
    host_u.writeReg(pmwg_pkg::REG_LINEAR, 8'h77, ack);
    check("lateAck", {7'h0, ack}, 8'h01);
    host_u.readReg(pmwg_pkg::REG_LINEAR, rd);
    check("lateStored", rd, 8'h77);
    check("buck3Code", outputCode[3], 8'h04);
    $display("Test lockout done");
    host_u.writeReg(8'h11, 8'hff, ack);
    t0 = $time;
    check("rampAck", {7'h0, ack}, 8'h01);
    host_u.lockWait(LOCK + 100);
    check("rampInReg", {7'h0, outputInRegulation[1]}, 8'h01);
    host_u.writeReg(8'h11, 8'h01, ack);
    check("rampNak", {7'h0, ack}, 8'h00);
    for (int i = 0; i < 6000 && outputCode[1] !== 8'hff; i++) begin
      @(posedge core_clk);
    end
    if (outputCode[1] !== 8'hff) begin
      check("rampDone", outputCode[1], 8'hff);
    end else begin
      // 255 steps of 20 cycles from the accept, a few cycles before t0
      check("rampTime", {7'h0, ($time - t0) / 100 inside {[5000:5110]}}, 8'h01);
      @(posedge core_clk);
      check("reEvaluated", {7'h0, outputInRegulation[1]}, 8'h00);
    end
    regulationRaw <= 5'h1f;
    repeat (5) @(posedge core_clk);
    check("rawPass", {3'h0, outputInRegulation}, 8'h1f);
    $display("Test ramp done");
    host_u.writeReg(pmwg_pkg::REG_ADC_EN, 8'h00, ack);
    check("adcOffAck", {7'h0, ack}, 8'h01);
    host_u.readReg(pmwg_pkg::REG_ADC_EN, rd);
    check("adcOffRead", rd, 8'h00);
    repeat (50) begin
      @(posedge core_clk);
      if (adcStart === 1'b1) begin
        nStart++;
      end
    end
    check("adcStopped", (nStart > 0) ? 8'h01 : 8'h00, 8'h00);
    $display("Test converter enable done");
    wrap_up();
  end
endmodule
`default_nettype wire
